/* verilog/mhbp_map.svh */
// Register selects, reset values and sizes of the modem host byte port
`ifndef MHBP_MAP_SVH
`define MHBP_MAP_SVH
`define MHBP_SEL_BUFFER 2'h0
`define MHBP_SEL_COMMAND 2'h1
`define MHBP_SEL_CONTROL 2'h2
`define MHBP_SEL_MODE 2'h3
`define MHBP_SEL_STATUS 2'h1
`define MHBP_SEL_QUALITY 2'h2
`define MHBP_BUF_DEPTH 12
`define MHBP_RESET_BYTE 8'h00
`endif

/* verilog/mhbp_pkg.sv */
// Types shared by the modem host byte port
package mhbp_pkg;
  typedef logic [7:0] mhbp_byte_t;
  // Synchronised host pins, sampled together
  typedef struct packed {
    logic cs_low;
    logic rd_low;
    logic wr_low;
    logic [1:0] sel;
    mhbp_byte_t data;
  } mhbp_host_s;
  typedef enum logic [1:0] {MHBP_IDLE, MHBP_READ, MHBP_WRITE} mhbp_state_e;
endpackage : mhbp_pkg

/* verilog/mhbp_host_port.sv */
// Byte-wide host port: pin sync, register decode, buffer, bus drive, interrupt pin
`include "mhbp_map.svh"
// What this block does
// - Interrupt pin pulls low while pending, otherwise released for wired-OR sharing.
// - Eight-line bidirectional data bus, driven by the device only during reads.
// - Reads and writes happen only while chip select is low.
// - Read strobe low puts the selected buffer, status or quality byte on the data lines; select 3 reads as zero.
// - Write strobe low captures data lines into the selected register.
// - Two select lines choose the addressed register.
// - Status and data quality registers are readable by the host.
// - Command, mode and control registers are host writable and drive the modem.
// - Twelve-byte buffer exchanges transmit and receive data with the host.
module mhbp_host_port #(
  parameter int DEPTH = `MHBP_BUF_DEPTH
) (
  input wire logic clock, // 10 MHz system clock
  input wire logic reset, // Synchronous, active high
  input wire logic chip_select_low, // Host chip select pin
  input wire logic read_strobe_low, // Host read strobe pin
  input wire logic write_strobe_low, // Host write strobe pin
  input wire logic register_select_bit0, // Register select pin 0
  input wire logic register_select_bit1, // Register select pin 1
  input wire logic [7:0] host_data_lines_in, // Level seen on data pins
  output logic [7:0] host_data_lines_out, // Data driven on read
  output logic host_data_lines_oe, // High while driving data pins
  output logic host_interrupt_request_low_out, // Always low when driven
  output logic host_interrupt_request_low_oe, // High while pulling interrupt low
  input wire logic irq_pending, // Modem core interrupt request
  input wire logic [7:0] modem_status, // Status byte from modem core
  input wire logic [7:0] modem_quality, // Data quality byte from modem core
  input wire logic buf_load, // Core writes a received byte
  input wire logic [3:0] buf_load_index, // Buffer entry for the core write
  input wire logic [7:0] buf_load_data, // Byte from the core
  input wire logic [3:0] buf_peek_index, // Buffer entry the core reads
  output logic [7:0] buf_peek_data, // Byte to the core
  output logic [7:0] command_reg, // Command register contents
  output logic [7:0] control_reg, // Control register contents
  output logic [7:0] mode_reg, // Mode register contents
  output logic command_written // One-cycle pulse on command write
);
  mhbp_pkg::mhbp_host_s sync1_q;
  mhbp_pkg::mhbp_host_s sync2_q;
  mhbp_pkg::mhbp_state_e state_q;
  mhbp_pkg::mhbp_byte_t buf_q [DEPTH];
  logic [3:0] ptr_q;
  logic [7:0] rdata_q;
  logic rd_active;
  logic wr_active;

  // Two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      sync1_q <= '{cs_low: 1'b1, rd_low: 1'b1, wr_low: 1'b1, sel: 2'h0, data: 8'h00};
      sync2_q <= '{cs_low: 1'b1, rd_low: 1'b1, wr_low: 1'b1, sel: 2'h0, data: 8'h00};
    end
    else
    begin
      sync1_q <= '{cs_low: chip_select_low, rd_low: read_strobe_low,
                   wr_low: write_strobe_low,
                   sel: {register_select_bit1, register_select_bit0},
                   data: host_data_lines_in};
      sync2_q <= sync1_q;
    end
  end

  // Strobes count only with chip select low
  assign rd_active = sync2_q.cs_low ? 1'b0 : !sync2_q.rd_low;
  assign wr_active = sync2_q.cs_low ? 1'b0 : !sync2_q.wr_low;

  // One action per strobe: a strobe must go away before the next is taken
  always_ff @(posedge clock)
  begin
    if (reset)
      state_q <= mhbp_pkg::MHBP_IDLE;
    else
    begin
      case (state_q)
        mhbp_pkg::MHBP_IDLE:
          if (rd_active)
            state_q <= mhbp_pkg::MHBP_READ;
          else if (wr_active)
            state_q <= mhbp_pkg::MHBP_WRITE;
        mhbp_pkg::MHBP_READ:
          if (!rd_active)
            state_q <= mhbp_pkg::MHBP_IDLE;
        mhbp_pkg::MHBP_WRITE:
          if (!wr_active)
            state_q <= mhbp_pkg::MHBP_IDLE;
        default:
          state_q <= mhbp_pkg::MHBP_IDLE;
      endcase
    end
  end

  wire take_write = (state_q == mhbp_pkg::MHBP_IDLE) && !rd_active && wr_active;
  wire take_read = (state_q == mhbp_pkg::MHBP_IDLE) && rd_active;

  // Host writes to command, control and mode; buffer select writes the buffer
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      command_reg <= `MHBP_RESET_BYTE;
      control_reg <= `MHBP_RESET_BYTE;
      mode_reg <= `MHBP_RESET_BYTE;
      command_written <= 1'b0;
    end
    else
    begin
      command_written <= take_write && (sync2_q.sel == `MHBP_SEL_COMMAND);
      if (take_write)
      begin
        case (sync2_q.sel)
          `MHBP_SEL_COMMAND: command_reg <= sync2_q.data;
          `MHBP_SEL_CONTROL: control_reg <= sync2_q.data;
          `MHBP_SEL_MODE: mode_reg <= sync2_q.data;
          default: ;
        endcase
      end
    end
  end

  // Host buffer pointer walks entries; restarts on a command write so
  // the host can fill or drain a fresh block
  always_ff @(posedge clock)
  begin
    if (reset)
      ptr_q <= 4'h0;
    else if (take_write && sync2_q.sel == `MHBP_SEL_COMMAND)
      ptr_q <= 4'h0;
    else if ((take_write || take_read) && sync2_q.sel == `MHBP_SEL_BUFFER)
      ptr_q <= (ptr_q == 4'(DEPTH - 1)) ? 4'h0 : ptr_q + 4'h1;
  end

  // Buffer entries; a host write wins over a core load to the same entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_buf
      always_ff @(posedge clock)
      begin
        if (reset)
          buf_q[gi] <= `MHBP_RESET_BYTE;
        else if (take_write && sync2_q.sel == `MHBP_SEL_BUFFER && ptr_q == 4'(gi))
          buf_q[gi] <= sync2_q.data;
        else if (buf_load && buf_load_index == 4'(gi))
          buf_q[gi] <= buf_load_data;
      end
    end
  endgenerate

  assign buf_peek_data = (buf_peek_index < 4'(DEPTH)) ? buf_q[buf_peek_index] : 8'h00;

  // Read data latched at the start of the read strobe and held through it
  always_ff @(posedge clock)
  begin
    if (reset)
      rdata_q <= 8'h00;
    else if (take_read)
    begin
      case (sync2_q.sel)
        `MHBP_SEL_BUFFER: rdata_q <= buf_q[ptr_q];
        `MHBP_SEL_STATUS: rdata_q <= modem_status;
        `MHBP_SEL_QUALITY: rdata_q <= modem_quality;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // Drive the bus only during an accepted read with select and strobe low
  assign host_data_lines_out = rdata_q;
  assign host_data_lines_oe = (state_q == mhbp_pkg::MHBP_READ) && rd_active;

  // Open drain: pull low while pending, release otherwise
  assign host_interrupt_request_low_out = 1'b0;
  assign host_interrupt_request_low_oe = irq_pending;

  a_bus_release_idle: assert property (@(posedge clock) disable iff (reset)
    (sync2_q.cs_low || sync2_q.rd_low) |-> !host_data_lines_oe)
    else $error("data bus driven without select and read");
  a_read_drives_bus: assert property (@(posedge clock) disable iff (reset)
    take_read |=> (rd_active -> host_data_lines_oe))
    else $error("read strobe did not drive bus");
  a_write_command: assert property (@(posedge clock) disable iff (reset)
    (take_write && sync2_q.sel == `MHBP_SEL_COMMAND) |=> command_reg == $past(sync2_q.data))
    else $error("command byte not captured");
  a_select_blocks: assert property (@(posedge clock) disable iff (reset)
    sync2_q.cs_low |-> !take_write && !take_read)
    else $error("access taken with chip select high");
  a_irq_follows: assert property (@(posedge clock) disable iff (reset)
    host_interrupt_request_low_oe == irq_pending && !host_interrupt_request_low_out)
    else $error("interrupt pin not following pending");
  a_mode_held: assert property (@(posedge clock) disable iff (reset)
    !(take_write && sync2_q.sel == `MHBP_SEL_MODE) |=> $stable(mode_reg))
    else $error("mode changed without write");
  a_status_read: assert property (@(posedge clock) disable iff (reset)
    (take_read && sync2_q.sel == `MHBP_SEL_STATUS) |=> rdata_q == $past(modem_status))
    else $error("status byte not returned");
  a_oe_only_read: assert property (@(posedge clock) disable iff (reset)
    host_data_lines_oe |-> state_q == mhbp_pkg::MHBP_READ)
    else $error("bus driven outside read");
  a_ptr_range: assert property (@(posedge clock) disable iff (reset)
    ptr_q < 4'(DEPTH))
    else $error("buffer pointer out of range");
  // One read per strobe, and control writes and quality reads land where the host aimed them
  a_deselect_holds: assert property (@(posedge clock) disable iff (reset)
    sync2_q.cs_low |=> $stable(control_reg))
    else $error("control changed while deselected");
  a_control_write: assert property (@(posedge clock) disable iff (reset)
    (take_write && sync2_q.sel == `MHBP_SEL_CONTROL) |=> control_reg == $past(sync2_q.data))
    else $error("control byte not captured");
  a_quality_read: assert property (@(posedge clock) disable iff (reset)
    (take_read && sync2_q.sel == `MHBP_SEL_QUALITY) |=> rdata_q == $past(modem_quality))
    else $error("quality byte not returned");
  a_command_pulse: assert property (@(posedge clock) disable iff (reset)
    (take_write && sync2_q.sel == `MHBP_SEL_COMMAND) |=> command_written)
    else $error("command pulse missing");
  a_read_once: assert property (@(posedge clock) disable iff (reset)
    take_read |=> !take_read)
    else $error("held read strobe taken twice");
endmodule : mhbp_host_port

/* sim/mhbp_host_model.sv */
// Host microcontroller model that drives the byte port pins
module mhbp_host_model (
  input wire logic clock, // System clock
  output logic cs_low, // Chip select pin
  output logic rd_low, // Read strobe pin
  output logic wr_low, // Write strobe pin
  output logic [1:0] sel, // Register select pins
  output logic [7:0] bus, // Resolved data pin level
  input wire logic [7:0] dev_out, // Device read data
  input wire logic dev_oe, // Device data drive enable
  input wire logic irq_oe, // Device interrupt pull enable
  input wire logic irq_out, // Device interrupt level while pulling
  output logic irq_line, // Shared interrupt line
  output logic [7:0] rdata // Last byte read, unknown if never driven
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] host_d = 8'h00;
  logic host_oe = 1'b0;
  logic [7:0] last = 8'h00;
  // Pull-up on the shared line, so a released pin reads high
  assign irq_line = irq_oe ? irq_out : 1'b1;
  // A released bus changes every cycle, so a stale byte never passes
  assign bus = dev_oe ? dev_out : (host_oe ? host_d : ~last);
  always @(posedge clock) last <= bus;
  initial
  begin
    cs_low = 1'b1;
    rd_low = 1'b1;
    wr_low = 1'b1;
    sel = 2'h0;
    rdata = 8'h00;
  end
  // One access: select and data settle 3 cycles before the strobe
  task automatic access(input logic is_rd, input logic [1:0] s, input logic [7:0] d,
                        input logic cs_on);
    int n;
    n = 0;
    @(negedge clock);
    sel = s;
    host_d = d;
    host_oe = !is_rd;
    repeat (3) @(negedge clock);
    cs_low = !cs_on;
    rd_low = !is_rd;
    wr_low = is_rd;
    repeat (4) @(negedge clock);
    while (is_rd && !dev_oe && n < 8)
    begin
      @(negedge clock);
      n++;
    end
    if (is_rd)
      rdata = dev_oe ? bus : 8'hXX;
    cs_low = 1'b1;
    rd_low = 1'b1;
    wr_low = 1'b1;
    host_oe = 1'b0;
    repeat (4) @(negedge clock);
  endtask : access
endmodule : mhbp_host_model

/* sim/test_modem_host_byte_port.sv */
// Self-checking bench of the modem host byte port
module test_modem_host_byte_port;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic rd; logic [1:0] s; logic [7:0] d; logic [7:0] exp;} mhbp_row_s;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cs_low, rd_low, wr_low, irq_pending = 1'b0, irq_line, oe, irq_oe, irq_out, cmd_wr;
  logic buf_load = 1'b0;
  logic [1:0] sel;
  logic [3:0] load_idx = 4'h0, peek_idx = 4'h0;
  logic [7:0] bus, dout, rdata, peek, command_reg, control_reg, mode_reg, got;
  logic [7:0] load_d = 8'h00;
  logic [7:0] status = 8'h96;
  int fail_count = 0, total_checks = 0, cycles = 0, cw_count = 0;
  mhbp_row_s rows [6] = '{'{0, 2'h1, 8'hA5, 8'hA5}, '{0, 2'h2, 8'h3C, 8'h3C},
    '{0, 2'h3, 8'h5A, 8'h5A}, '{1, 2'h1, 8'h00, 8'h96}, '{1, 2'h2, 8'h00, 8'h4B},
    '{1, 2'h3, 8'h00, 8'h00}};
  initial forever #50 clock = ~clock;
  mhbp_host_port u_mhbp_host_port (.clock(clock), .reset(reset), .chip_select_low(cs_low),
    .read_strobe_low(rd_low), .write_strobe_low(wr_low), .register_select_bit0(sel[0]),
    .register_select_bit1(sel[1]), .host_data_lines_in(bus), .host_data_lines_out(dout),
    .host_data_lines_oe(oe), .host_interrupt_request_low_out(irq_out),
    .host_interrupt_request_low_oe(irq_oe), .irq_pending(irq_pending),
    .modem_status(status), .modem_quality(8'h4B), .buf_load(buf_load),
    .buf_load_index(load_idx), .buf_load_data(load_d), .buf_peek_index(peek_idx),
    .buf_peek_data(peek), .command_reg(command_reg), .control_reg(control_reg),
    .mode_reg(mode_reg), .command_written(cmd_wr));
  mhbp_host_model u_host (.clock(clock), .cs_low(cs_low), .rd_low(rd_low), .wr_low(wr_low),
    .sel(sel), .bus(bus), .dev_out(dout), .dev_oe(oe), .irq_oe(irq_oe), .irq_out(irq_out),
    .irq_line(irq_line), .rdata(rdata));
  // Count command pulses mid-cycle, clear of the edge that launches them; cut a hang short
  always @(negedge clock)
  begin
    cw_count += (cmd_wr === 1'b1);
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic [7:0] reg_of(input logic [1:0] s);
    return (s == 2'h1) ? command_reg : ((s == 2'h2) ? control_reg : mode_reg);
  endfunction : reg_of
  task automatic check(input logic [7:0] g, input logic [7:0] exp);
    total_checks++;
    if (g !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    repeat (5) @(negedge clock);
    reset = 1'b0;
    check(command_reg, 8'h00);
    check(control_reg, 8'h00);
    check(mode_reg, 8'h00);
    check({7'h00, oe}, 8'h00);
    check({7'h00, irq_line}, 8'h01);
    $display("test reset done");
    foreach (rows[i])
    begin
      u_host.access(rows[i].rd, rows[i].s, rows[i].d, 1'b1);
      got = rows[i].rd ? rdata : reg_of(rows[i].s);
      check(got, rows[i].exp);
      check({7'h00, oe}, 8'h00);
    end
    check(cw_count[7:0], 8'h01);
    $display("test table done");
    // Deselected strobes must change nothing and never drive the bus
    u_host.access(1'b0, 2'h2, 8'hFF, 1'b0);
    check(control_reg, 8'h3C);
    u_host.access(1'b1, 2'h1, 8'h00, 1'b0);
    check(rdata, 8'hXX);
    irq_pending = 1'b1;
    #1 check({7'h00, irq_line}, 8'h00);
    @(negedge clock);
    irq_pending = 1'b0;
    #1 check({7'h00, irq_line}, 8'h01);
    $display("test select and interrupt done");
    // Thirteen writes after a command wrap the pointer, so the thirteenth lands in entry 0
    u_host.access(1'b0, 2'h1, 8'h01, 1'b1);
    for (int i = 0; i < 13; i++)
      u_host.access(1'b0, 2'h0, 8'h10 + i[7:0], 1'b1);
    peek_idx = 4'h0;
    #1 check(peek, 8'h1C);
    @(negedge clock);
    peek_idx = 4'hB;
    #1 check(peek, 8'h1B);
    u_host.access(1'b0, 2'h1, 8'h02, 1'b1);
    u_host.access(1'b1, 2'h0, 8'h00, 1'b1);
    check(rdata, 8'h1C);
    @(negedge clock);
    buf_load = 1'b1;
    load_idx = 4'h5;
    load_d = 8'hE7;
    @(negedge clock);
    buf_load = 1'b0;
    peek_idx = 4'h5;
    #1 check(peek, 8'hE7);
    @(negedge clock);
    peek_idx = 4'hC;
    #1 check(peek, 8'h00);
    $display("test buffer done");
    // A fresh status byte must be returned, not one left from an earlier read
    @(negedge clock);
    status = 8'h69;
    u_host.access(1'b1, 2'h1, 8'h00, 1'b1);
    check(rdata, 8'h69);
    // Reset in mid-run clears registers, buffer and pointer; the next write lands
    @(negedge clock);
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    check(command_reg, 8'h00);
    check(control_reg, 8'h00);
    check(mode_reg, 8'h00);
    check({7'h00, oe}, 8'h00);
    peek_idx = 4'h0;
    #1 check(peek, 8'h00);
    u_host.access(1'b0, 2'h2, 8'h77, 1'b1);
    check(control_reg, 8'h77);
    u_host.access(1'b1, 2'h0, 8'h00, 1'b1);
    check(rdata, 8'h00);
    $display("test mid-run reset done");
    end_sim();
  end
endmodule : test_modem_host_byte_port
